// File: design/uart_rx_ext.sv
// design: uart receiver with multiprocessor filter, lin break/sync detect and autobaud
// What this block does
// R1: extra bit one means address, zero data
// R2: with both enables, interrupt only on address
// R3: address match enabled drops data frames silently
// R4: firmware clears match enable after own address
// R5: buffer takes frame if room and check passes
// R6: lin mode enables break and sync detection
// R7: break then sync detected even mid-stream
// R8: break sets break done flag
// R9: valid sync sets detected, timeout sets timeout
// R10: each lin flag has own interrupt enable
// R11: autobaud runs only while its enable set
// R12: lin autobaud needs break, delimiter, then sync
// R13: lin autobaud leaves normal frames undisturbed
// R14: without lin, next word measured as sync
// R15: measured sync loads reload with current prescaler
// R16: count prescaled clocks first to last rise
// R17: reload is 0x10000 minus half bit count, max 0xffce
// R18: firmware keeps at least 100 clocks per bit
// R19: firmware disables non-lin autobaud after sync
// R20: rx source is pin or logic unit zero..two
// R21: selected rx input synchronised before use
// R22: break is low for eleven bit times
module uart_rx_ext (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire uart_rx_ext_pkg::avl_req_t    avl_req,
  output logic                              avl_waitrequest_q,
  output logic [31:0]                       avl_readdata_q,
  input  wire uart_rx_ext_pkg::rx_sources_t rx_sources,
  output logic                              uart_irq_q
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  typedef enum logic [2:0] {
    SY_IDLE  = 3'b000,
    SY_DELIM = 3'b001,
    SY_ARMED = 3'b010,
    SY_FIRST = 3'b011,
    SY_MEAS  = 3'b100
  } sync_state_t;

  logic [7:0]  ctl_q;             // serial control bits
  logic [7:0]  mode_q;            // serial mode bits
  logic [7:0]  lin_q;             // lin configuration and flags
  logic [1:0]  src_sel_q;         // rx_source_select
  logic [15:0] reload_q;          // baud_reload_value
  logic [7:0]  rx_data_q;         // receive buffer, one entry
  logic        rx_sync1_q;        // first synchroniser stage
  logic        rx_line_q;         // synchronised rx line
  logic        rx_prev_q;         // line one cycle ago
  logic [5:0]  pre_cnt_q;         // prescaler divider
  logic        pre_tick;          // one prescaled clock
  logic [15:0] brg_q;             // baud counter
  logic        half_tick;         // baud counter overflow, twice per bit
  rx_state_t   rx_state_q;        // receiver state
  logic        phase_q;           // half-bit phase inside a bit
  logic [3:0]  bit_cnt_q;         // bits taken so far
  logic [8:0]  shift_q;           // data plus extra bit
  logic [4:0]  low_cnt_q;         // half bits the line stayed low
  sync_state_t sy_state_q;        // sync measurement state
  logic [19:0] sy_cnt_q;          // prescaled clocks measured
  logic [2:0]  sy_rise_q;         // rising edges after the first
  logic        acc;               // bus access completes this cycle
  logic        wr_acc;            // write completes this cycle
  logic [7:0]  idx;               // register index from byte address
  logic        fall;              // line falling edge
  logic        rise;              // line rising edge
  logic        frame_done;        // stop bit sampled
  logic        frame_accept;      // frame enters buffer
  logic        break_hit;         // break recognised this cycle
  logic        sync_ok;           // valid sync this cycle
  logic        sync_to;           // sync timeout this cycle
  logic        rx_in;             // selected receive source
  logic [15:0] half_bit;          // measured counts per half bit
  logic        lin_on;            // lin mode shorthand
  logic        sync_active;       // sync detector may run
  localparam logic [2:0] SYNC_LAST = uart_rx_ext_pkg::SYNC_RISES_AFTER - 3'h1; // last counted rise

  assign acc    = (avl_req.read | avl_req.write) & ~avl_waitrequest_q;
  assign wr_acc = avl_req.write & ~avl_waitrequest_q;
  assign idx    = avl_req.address[9:2];
  assign lin_on = lin_q[uart_rx_ext_pkg::LIN_MODE];
  assign fall   = rx_prev_q & ~rx_line_q;
  assign rise   = ~rx_prev_q & rx_line_q;
  assign sync_active = lin_on | lin_q[uart_rx_ext_pkg::LIN_AUTOBAUD];

  // ****************************************************************
  // receive source select and synchroniser
  // ****************************************************************
  // source mux, zero is the crossbar pin after reset
  always_comb
  begin
    unique case (src_sel_q)
      2'h0: rx_in = rx_sources.pin; // R20
      2'h1: rx_in = rx_sources.clu_out[0];
      2'h2: rx_in = rx_sources.clu_out[1];
      2'h3: rx_in = rx_sources.clu_out[2];
    endcase
  end

  // two stages; only the second stage feeds detection logic
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rx_sync1_q <= 1'b1;
      rx_line_q  <= 1'b1;
      rx_prev_q  <= 1'b1;
    end
    else
    begin
      rx_sync1_q <= rx_in; // R21
      rx_line_q  <= rx_sync1_q;
      rx_prev_q  <= rx_line_q;
    end
  end

  // ****************************************************************
  // prescaler and baud generator
  // ****************************************************************
  // prescaler divides by 1, 4, 16 or 64
  always_comb
  begin
    unique case (mode_q[uart_rx_ext_pkg::MOD_PRESC_LSB +: 2])
      2'h0: pre_tick = 1'b1;
      2'h1: pre_tick = (pre_cnt_q[1:0] == 2'h3);
      2'h2: pre_tick = (pre_cnt_q[3:0] == 4'hf);
      2'h3: pre_tick = (pre_cnt_q == 6'h3f);
    endcase
  end

  // free running divider
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      pre_cnt_q <= 6'h00;
    else
      pre_cnt_q <= pre_cnt_q + 6'h01;
  end

  assign half_tick = pre_tick & (brg_q == 16'hffff);

  // counts up from reload; restarts at a start edge so bits centre
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      brg_q <= uart_rx_ext_pkg::BAUD_RELOAD_RST;
    else if (rx_state_q == RX_IDLE && fall)
      brg_q <= reload_q;
    else if (half_tick)
      brg_q <= reload_q; // R17
    else if (pre_tick)
      brg_q <= brg_q + 16'h0001;
  end

  // ****************************************************************
  // break detector
  // ****************************************************************
  assign break_hit = lin_on & half_tick & ~rx_line_q
                     & (low_cnt_q == uart_rx_ext_pkg::BREAK_HALF_BITS - 5'h01); // R22

  // counts half bits of low line, saturating after the break point
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      low_cnt_q <= 5'h00;
    else if (rx_line_q)
      low_cnt_q <= 5'h00;
    else if (half_tick && low_cnt_q != uart_rx_ext_pkg::BREAK_HALF_BITS)
      low_cnt_q <= low_cnt_q + 5'h01;
  end

  // ****************************************************************
  // receiver
  // ****************************************************************
  assign frame_done   = (rx_state_q == RX_STOP) & half_tick & phase_q;
  // checked bit is the extra bit when enabled, else the stop bit
  assign frame_accept = frame_done & ~ctl_q[uart_rx_ext_pkg::CTL_RX_FLAG]
                        & (~mode_q[uart_rx_ext_pkg::MOD_ADDR_MATCH]
                           | (mode_q[uart_rx_ext_pkg::MOD_EXTRA_EN] ? shift_q[8] : rx_line_q)); // R5 R2 R3 R1

  // frame sequencer; a break aborts any frame in progress
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rx_state_q <= RX_IDLE;
      phase_q    <= 1'b0;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 9'h000;
    end
    else if (break_hit || !ctl_q[uart_rx_ext_pkg::CTL_RX_ENABLE])
    begin
      rx_state_q <= RX_IDLE; // R7
      phase_q    <= 1'b0;
    end
    else
    begin
      unique case (rx_state_q)
        RX_IDLE:
        begin
          // wait for a start edge on an idle-high line
          if (fall && low_cnt_q == 5'h00)
            rx_state_q <= RX_START;
          phase_q   <= 1'b0;
          bit_cnt_q <= 4'h0;
        end
        RX_START:
        begin
          // middle of start bit: line must still be low
          if (half_tick)
            rx_state_q <= rx_line_q ? RX_IDLE : RX_DATA;
        end
        RX_DATA:
        begin
          if (half_tick)
          begin
            phase_q <= ~phase_q;
            if (phase_q)
            begin
              // lsb first; the extra bit lands in bit 8
              shift_q   <= {rx_line_q, shift_q[8:1]};
              bit_cnt_q <= bit_cnt_q + 4'h1;
              if (bit_cnt_q == uart_rx_ext_pkg::DATA_BITS
                               - {3'h0, ~mode_q[uart_rx_ext_pkg::MOD_EXTRA_EN]})
                rx_state_q <= RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (half_tick)
          begin
            phase_q <= ~phase_q;
            if (phase_q)
              rx_state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // buffer entry; without extra bit the data sits one place higher
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rx_data_q <= 8'h00;
    else if (frame_accept)
      rx_data_q <= mode_q[uart_rx_ext_pkg::MOD_EXTRA_EN] ? shift_q[7:0] : shift_q[8:1];
  end

  // ****************************************************************
  // sync field detector and autobaud measurement
  // ****************************************************************
  assign half_bit = sy_cnt_q[19:4]; // eight bit times over sixteen
  assign sync_ok  = (sy_state_q == SY_MEAS) & rise & (sy_rise_q == SYNC_LAST)
                    & (half_bit >= uart_rx_ext_pkg::HALF_BIT_MIN);
  assign sync_to  = ((sy_state_q == SY_FIRST || sy_state_q == SY_MEAS)
                     & pre_tick & (sy_cnt_q == uart_rx_ext_pkg::SYNC_CNT_MAX))
                    | ((sy_state_q == SY_MEAS) & rise & (sy_rise_q == SYNC_LAST)
                       & (half_bit < uart_rx_ext_pkg::HALF_BIT_MIN));

  // break arms the lin path; outside lin the next word is measured
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sy_state_q <= SY_IDLE;
      sy_cnt_q   <= 20'h00000;
      sy_rise_q  <= 3'h0;
    end
    else if (!sync_active)
      sy_state_q <= SY_IDLE;
    else if (break_hit)
      sy_state_q <= SY_DELIM; // R6 R7 R12 R13
    else
    begin
      unique case (sy_state_q)
        SY_IDLE:
        begin
          // without lin, autobaud arms at once
          if (!lin_on && lin_q[uart_rx_ext_pkg::LIN_AUTOBAUD])
            sy_state_q <= SY_ARMED; // R14 R11
        end
        SY_DELIM:
        begin
          // delimiter: line back high after the break
          if (rx_line_q)
            sy_state_q <= SY_ARMED; // R12
        end
        SY_ARMED:
        begin
          if (fall)
          begin
            sy_state_q <= SY_FIRST;
            sy_cnt_q   <= 20'h00000;
          end
        end
        SY_FIRST:
        begin
          // waiting for the first rising edge, end of start bit
          if (rise)
          begin
            sy_state_q <= SY_MEAS;
            // the tick in the cycle of the first rise belongs to the span
            sy_cnt_q   <= {19'h00000, pre_tick}; // R16
            sy_rise_q  <= 3'h0;
          end
          else if (sync_to)
            sy_state_q <= SY_IDLE;
          else if (pre_tick)
            sy_cnt_q <= sy_cnt_q + 20'h00001;
        end
        SY_MEAS:
        begin
          if (sync_ok || sync_to)
            sy_state_q <= SY_IDLE;
          else
          begin
            if (pre_tick)
              sy_cnt_q <= sy_cnt_q + 20'h00001; // R16
            if (rise)
              sy_rise_q <= sy_rise_q + 3'h1;
          end
        end
        default:
          sy_state_q <= SY_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  // control and mode bits written by software; flags set by hardware win
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctl_q     <= 8'h00;
      mode_q    <= 8'h00;
      lin_q     <= 8'h00;
      src_sel_q <= 2'h0;
    end
    else
    begin
      if (wr_acc && idx == uart_rx_ext_pkg::IDX_SERIAL_CONTROL)
      begin
        ctl_q[uart_rx_ext_pkg::CTL_RX_ENABLE] <= avl_req.writedata[uart_rx_ext_pkg::CTL_RX_ENABLE];
        ctl_q[uart_rx_ext_pkg::CTL_RX_IRQ_EN] <= avl_req.writedata[uart_rx_ext_pkg::CTL_RX_IRQ_EN];
      end
      // receive flag: set on acceptance, cleared by data read or write one
      if (frame_accept)
      begin
        ctl_q[uart_rx_ext_pkg::CTL_RX_FLAG]  <= 1'b1; // R2 R3
        ctl_q[uart_rx_ext_pkg::CTL_RX_EXTRA] <= mode_q[uart_rx_ext_pkg::MOD_EXTRA_EN] ? shift_q[8] : rx_line_q;
      end
      else if ((acc && avl_req.read && idx == uart_rx_ext_pkg::IDX_RX_DATA)
               || (wr_acc && idx == uart_rx_ext_pkg::IDX_SERIAL_CONTROL
                   && avl_req.writedata[uart_rx_ext_pkg::CTL_RX_FLAG]))
        ctl_q[uart_rx_ext_pkg::CTL_RX_FLAG] <= 1'b0;
      if (wr_acc && idx == uart_rx_ext_pkg::IDX_SERIAL_MODE)
        mode_q <= {4'h0, avl_req.writedata[3:0]};
      if (wr_acc && idx == uart_rx_ext_pkg::IDX_RX_PIN_SOURCE)
        src_sel_q <= avl_req.writedata[1:0]; // R20
      if (wr_acc && idx == uart_rx_ext_pkg::IDX_LIN_CONFIG)
        lin_q[4:0] <= avl_req.writedata[4:0];
      // sticky lin flags, write one to clear, set wins
      lin_q[uart_rx_ext_pkg::LIN_BREAK_FLAG] <= break_hit
        | (lin_q[uart_rx_ext_pkg::LIN_BREAK_FLAG] & ~(wr_acc && idx == uart_rx_ext_pkg::IDX_LIN_CONFIG
           && avl_req.writedata[uart_rx_ext_pkg::LIN_BREAK_FLAG])); // R8
      lin_q[uart_rx_ext_pkg::LIN_SYNC_FLAG] <= sync_ok
        | (lin_q[uart_rx_ext_pkg::LIN_SYNC_FLAG] & ~(wr_acc && idx == uart_rx_ext_pkg::IDX_LIN_CONFIG
           && avl_req.writedata[uart_rx_ext_pkg::LIN_SYNC_FLAG])); // R9
      lin_q[uart_rx_ext_pkg::LIN_TIMEOUT_FLAG] <= sync_to
        | (lin_q[uart_rx_ext_pkg::LIN_TIMEOUT_FLAG] & ~(wr_acc && idx == uart_rx_ext_pkg::IDX_LIN_CONFIG
           && avl_req.writedata[uart_rx_ext_pkg::LIN_TIMEOUT_FLAG])); // R9
    end
  end

  // reload: autobaud result wins over a software write in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      reload_q <= uart_rx_ext_pkg::BAUD_RELOAD_RST;
    else if (sync_ok && lin_q[uart_rx_ext_pkg::LIN_AUTOBAUD])
      reload_q <= 16'(uart_rx_ext_pkg::BAUD_WRAP - {1'b0, half_bit}); // R15 R17 R11
    else if (wr_acc && idx == uart_rx_ext_pkg::IDX_BAUD_LOW)
      reload_q[7:0] <= avl_req.writedata[7:0];
    else if (wr_acc && idx == uart_rx_ext_pkg::IDX_BAUD_HIGH)
      reload_q[15:8] <= avl_req.writedata[7:0];
  end

  // ****************************************************************
  // avalon slave: one wait state, then read data with waitrequest low
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      avl_waitrequest_q <= 1'b1;
      avl_readdata_q    <= 32'h0000_0000;
    end
    else
    begin
      avl_waitrequest_q <= ~((avl_req.read | avl_req.write) & avl_waitrequest_q);
      if (avl_req.read && avl_waitrequest_q)
      begin
        unique case (idx)
          uart_rx_ext_pkg::IDX_SERIAL_CONTROL:  avl_readdata_q <= {24'h0, ctl_q};
          uart_rx_ext_pkg::IDX_SERIAL_MODE:     avl_readdata_q <= {24'h0, mode_q};
          uart_rx_ext_pkg::IDX_RX_DATA:         avl_readdata_q <= {24'h0, rx_data_q};
          uart_rx_ext_pkg::IDX_BAUD_LOW:        avl_readdata_q <= {24'h0, reload_q[7:0]};
          uart_rx_ext_pkg::IDX_BAUD_HIGH:       avl_readdata_q <= {24'h0, reload_q[15:8]};
          uart_rx_ext_pkg::IDX_LIN_CONFIG:      avl_readdata_q <= {24'h0, lin_q};
          uart_rx_ext_pkg::IDX_RX_PIN_SOURCE:   avl_readdata_q <= {30'h0, src_sel_q};
          uart_rx_ext_pkg::IDX_FIFO_BYTE_COUNT:
            avl_readdata_q <= {31'h0, ctl_q[uart_rx_ext_pkg::CTL_RX_FLAG]};
          default:                              avl_readdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // interrupt output
  // ****************************************************************
  // each flag gated by its own enable
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      uart_irq_q <= 1'b0;
    else
      uart_irq_q <= (ctl_q[uart_rx_ext_pkg::CTL_RX_FLAG] & ctl_q[uart_rx_ext_pkg::CTL_RX_IRQ_EN])
                  | (lin_q[uart_rx_ext_pkg::LIN_BREAK_FLAG] & lin_q[uart_rx_ext_pkg::LIN_BREAK_IE])
                  | (lin_q[uart_rx_ext_pkg::LIN_SYNC_FLAG] & lin_q[uart_rx_ext_pkg::LIN_SYNC_IE])
                  | (lin_q[uart_rx_ext_pkg::LIN_TIMEOUT_FLAG] & lin_q[uart_rx_ext_pkg::LIN_TIMEOUT_IE]); // R10
  end

endmodule // uart_rx_ext

// File: common/uart_rx_ext_pkg.sv
// package: register map, field positions, reset values, timing and carrier types of the uart receive extensions
package uart_rx_ext_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_SERIAL_CONTROL  = 8'hc0; // receive flag, extra bit, rx enable
  localparam logic [7:0] IDX_SERIAL_MODE     = 8'hc1; // extra bit, address match, prescaler
  localparam logic [7:0] IDX_RX_DATA         = 8'hc2; // received byte, read clears receive flag
  localparam logic [7:0] IDX_BAUD_LOW        = 8'hc3; // baud_reload_low
  localparam logic [7:0] IDX_BAUD_HIGH       = 8'hc4; // baud_reload_high
  localparam logic [7:0] IDX_LIN_CONFIG      = 8'hc5; // lin_config_register
  localparam logic [7:0] IDX_RX_PIN_SOURCE   = 8'hda; // rx_pin_source_config
  localparam logic [7:0] IDX_FIFO_BYTE_COUNT = 8'hfa; // fifo_byte_count

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTL_RX_FLAG     = 0; // receive flag, write one clears
  localparam int CTL_RX_EXTRA    = 1; // received_extra_bit (or stop bit)
  localparam int CTL_RX_ENABLE   = 4; // receiver enable
  localparam int CTL_RX_IRQ_EN   = 5; // receive interrupt enable
  localparam int MOD_EXTRA_EN    = 0; // extra_bit_enable
  localparam int MOD_ADDR_MATCH  = 1; // address_match_enable
  localparam int MOD_PRESC_LSB   = 2; // prescaler select, two bits
  localparam int LIN_MODE        = 0; // lin_mode_enable
  localparam int LIN_AUTOBAUD    = 1; // autobaud_enable
  localparam int LIN_BREAK_IE    = 2; // break_done_irq_enable
  localparam int LIN_SYNC_IE     = 3; // sync_detected_irq_enable
  localparam int LIN_TIMEOUT_IE  = 4; // sync_timeout_irq_enable
  localparam int LIN_BREAK_FLAG  = 5; // break_done_flag, write one clears
  localparam int LIN_SYNC_FLAG   = 6; // sync_detected_flag, write one clears
  localparam int LIN_TIMEOUT_FLAG = 7; // sync_timeout_flag, write one clears

  // ****************************************************************
  // reset values and counts
  // ****************************************************************
  localparam logic [15:0] BAUD_RELOAD_RST  = 16'hfe00; // plain default reload
  localparam logic [15:0] BAUD_RELOAD_MAX  = 16'hffce; // largest valid reload
  localparam logic [15:0] HALF_BIT_MIN     = 16'h0032; // least counts per half bit (50)
  localparam logic [16:0] BAUD_WRAP        = 17'h10000; // counter wrap point
  localparam logic [4:0]  BREAK_HALF_BITS  = 5'h16;     // eleven bit times in half bits (22)
  localparam logic [2:0]  SYNC_RISES_AFTER = 3'h4;      // rising edges after the first one
  localparam logic [19:0] SYNC_CNT_MAX     = 20'hfffff; // measurement timeout
  localparam logic [3:0]  DATA_BITS        = 4'h8;      // data bits per frame

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic        read;      // avalon read strobe
    logic        write;     // avalon write strobe
    logic [9:0]  address;   // byte address
    logic [31:0] writedata; // write data
  } avl_req_t;

  typedef struct packed {
    logic [2:0] clu_out; // configurable logic unit outputs two..zero
    logic       pin;     // serial_receive_input from the crossbar
  } rx_sources_t;

endpackage : uart_rx_ext_pkg

// File: verif/uart_rx_ext_chk.sv
// checker: bus handshake, reset and interrupt relations
module uart_rx_ext_chk (
  input wire logic                         clk_sys,
  input wire logic                         rst_n,
  input wire uart_rx_ext_pkg::avl_req_t    avl_req,
  input wire logic                         avl_waitrequest_q,
  input wire logic [31:0]                  avl_readdata_q,
  input wire uart_rx_ext_pkg::rx_sources_t rx_sources,
  input wire logic                         uart_irq_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire       req = avl_req.read | avl_req.write; // any access
  wire [7:0] idx = avl_req.address[9:2];         // register index
  wire       hit = (idx >= 8'hc0 && idx <= 8'hc5) || idx == 8'hda || idx == 8'hfa;
  AST_WAIT_ONE: assert property (req && avl_waitrequest_q |=> !avl_waitrequest_q)
    else $error("access not completed after one wait state");
  AST_WAIT_PULSE: assert property (!avl_waitrequest_q |=> avl_waitrequest_q)
    else $error("waitrequest low too long");
  AST_WAIT_CAUSE: assert property (!avl_waitrequest_q |-> $past(req))
    else $error("completion without request");
  AST_RST_STATE: assert property (disable iff (1'b0) !rst_n |=> avl_waitrequest_q && avl_readdata_q == 32'h0 && !uart_irq_q)
    else $error("outputs not in reset state");
  AST_RDATA_HOLD: assert property ($changed(avl_readdata_q) && $past(rst_n) |-> !avl_waitrequest_q && $past(avl_req.read))
    else $error("read data moved outside a read");
  AST_RDATA_NARROW: assert property (!avl_waitrequest_q |-> avl_readdata_q[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_UNMAPPED: assert property (avl_req.read && avl_waitrequest_q && !hit |=> avl_readdata_q == 32'h0)
    else $error("unmapped read not zero");
  AST_IRQ_FALL: assert property ($fell(uart_irq_q) && $past(rst_n) |-> !$past(avl_waitrequest_q) || !$past(avl_waitrequest_q, 2))
    else $error("interrupt dropped without bus access");
endmodule // uart_rx_ext_chk

// File: verif/serial_master_model.sv
// model: serial master driving frames and breaks on the receive line
module serial_master_model (
  input  wire logic clk_sys,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line = 1'b1; // idle high, as pulled up
  // hold the line at a level for n clock cycles
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge clk_sys);
  endtask
  // start bit, nb bits lsb first, stop bit; bt cycles per bit
  task automatic frame(input logic [8:0] d, input int nb, input int bt);
    hold(1'b0, bt);
    for (int i = 0; i < nb; i++) hold(d[i], bt);
    hold(1'b1, bt);
  endtask
endmodule // serial_master_model

// File: verif/uart_rx_ext_tb.sv
// testbench: register bus, multiprocessor filter, source select, lin and autobaud
module uart_rx_ext_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                         clk_sys, rst_n, line, wait_q, irq_q;
  logic [31:0]                  rdata_q, rd;
  logic [1:0]                   sel;
  int                           miscompares, total_checks;
  uart_rx_ext_pkg::avl_req_t    avl_req;
  uart_rx_ext_pkg::rx_sources_t rx_sources;
  // selected source carries the line, the others idle high
  assign rx_sources = uart_rx_ext_pkg::rx_sources_t'(~(4'h1 << sel) | {4{line}});
  uart_rx_ext u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .avl_req(avl_req), .avl_waitrequest_q(wait_q),
                     .avl_readdata_q(rdata_q), .rx_sources(rx_sources), .uart_irq_q(irq_q));
  serial_master_model u_far (.clk_sys(clk_sys), .line(line));
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("BAD %s exp %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    avl_req <= {~wr, wr, idx, 2'b00, 24'h0, wd};
    do begin @(posedge clk_sys); n++; end while (wait_q !== 1'b0 && n < 20);
    rd = rdata_q;
    avl_req <= '0;
    @(posedge clk_sys);
    if (n >= 20)
    begin
      miscompares++; // bus never answered
      wrap_up();
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(nm, rd, exp);
  endtask
  task automatic t_bus();
    rchk("unmapped", 8'h10, 32'h0);
    bus(1'b1, 8'hc3, 8'hce); // fastest reload, 100 clocks a bit
    bus(1'b1, 8'hc4, 8'hff);
    rchk("baud_low", 8'hc3, 32'hce);
    $display("test bus done");
  endtask
  task automatic t_mp();
    bus(1'b1, 8'hc1, 8'h03); // extra bit and address match on
    bus(1'b1, 8'hc0, 8'h30); // receive and its interrupt on
    u_far.frame(9'h033, 9, 100); // data frame
    chk("irq_data", irq_q, 32'h0);
    bus(1'b0, 8'hc0, 8'h00);
    chk("flag_data", rd[0], 32'h0);
    u_far.frame(9'h15a, 9, 100); // address frame
    chk("irq_addr", irq_q, 32'h1);
    rchk("ctl_addr", 8'hc0, 32'h33);
    rchk("addr", 8'hc2, 32'h5a);
    bus(1'b1, 8'hc1, 8'h01); // addressed: accept data
    u_far.frame(9'h0a7, 9, 100);
    rchk("data", 8'hc2, 32'ha7);
    $display("test mp done");
  endtask
  task automatic t_src();
    bus(1'b1, 8'hc1, 8'h00);
    for (int k = 1; k < 4; k++)
    begin
      bus(1'b1, 8'hda, 8'(k));
      sel <= 2'(k);
      u_far.frame(9'h0c0 + 9'(k), 8, 100);
      rchk("src_data", 8'hc2, 32'hc0 + k);
    end
    bus(1'b1, 8'hda, 8'h00);
    sel <= 2'd0;
    $display("test src done");
  endtask
  task automatic t_lin();
    bus(1'b1, 8'hc0, 8'h10); // receive on, its interrupt off
    bus(1'b1, 8'hc5, 8'h07); // lin, autobaud, break interrupt
    u_far.hold(1'b0, 1300); // break, 13 bit times
    u_far.hold(1'b1, 200); // delimiter
    chk("irq_break", irq_q, 32'h1);
    rchk("lin_break", 8'hc5, 32'h27);
    u_far.frame(9'h055, 8, 128);
    rchk("lin_sync", 8'hc5, 32'h67);
    rchk("baud_low", 8'hc3, 32'hc0);
    rchk("baud_high", 8'hc4, 32'hff);
    bus(1'b1, 8'hc5, 8'he7); // clear the three flags
    rchk("lin_clear", 8'hc5, 32'h07);
    chk("irq_clear", irq_q, 32'h0);
    u_far.hold(1'b0, 1600);
    u_far.hold(1'b1, 300);
    u_far.frame(9'h055, 8, 96); // half bit under 50 counts
    rchk("lin_tmo", 8'hc5, 32'ha7);
    rchk("baud_keep", 8'hc3, 32'hc0);
    $display("test lin done");
  endtask
  task automatic t_abd();
    bus(1'b1, 8'hc5, 8'he2); // autobaud without lin, old flags cleared
    u_far.frame(9'h055, 8, 160);
    rchk("abd_sync", 8'hc5, 32'h42);
    rchk("abd_low", 8'hc3, 32'hb0);
    bus(1'b1, 8'hc5, 8'h40);
    rchk("abd_off", 8'hc5, 32'h00);
    $display("test abd done");
  endtask
  initial
  begin
    rst_n = 1'b0;
    avl_req = '0;
    sel = 2'd0;
    miscompares = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_bus();
    t_mp();
    t_src();
    t_lin();
    t_abd();
    wrap_up();
  end
endmodule // uart_rx_ext_tb
bind uart_rx_ext uart_rx_ext_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .avl_req(avl_req),
  .avl_waitrequest_q(avl_waitrequest_q), .avl_readdata_q(avl_readdata_q), .rx_sources(rx_sources),
  .uart_irq_q(uart_irq_q));
